// file: common/modfreq_consts.vh
// constants for the modulation and frequency configuration bank
`ifndef MODFREQ_CONSTS_VH
`define MODFREQ_CONSTS_VH

// register offsets
`define ADDR_MOD_CTRL2      7'h71
`define ADDR_DEV_LOW        7'h72
`define ADDR_OFS_LOW        7'h73
`define ADDR_OFS_HIGH       7'h74
`define ADDR_BAND_SEL       7'h75

// reset values
`define RST_MOD_CTRL2       8'h00
`define RST_DEV_LOW         8'h20
`define RST_OFS_LOW         8'h00
`define RST_OFS_HIGH        2'h0
`define RST_BAND_SEL        7'h75

// field positions in modulation control two
`define F_ROUTE_HI          7
`define F_ROUTE_LO          6
`define F_SRC_HI            5
`define F_SRC_LO            4
`define F_INV               3
`define F_DEV_MSB           2
`define F_KIND_HI           1
`define F_KIND_LO           0

// field positions in band select
`define F_SIDEBAND          6
`define F_HIGHBAND          5
`define F_BAND_HI           4

// bit clock routes
`define ROUTE_NONE          2'h0
`define ROUTE_GPIO          2'h1
`define ROUTE_SDO           2'h2
`define ROUTE_IRQ           2'h3

// modulation sources
`define SRC_GPIO            2'h0
`define SRC_SDI             2'h1
`define SRC_FIFO            2'h2
`define SRC_PN9             2'h3

// modulation types
`define MT_CARRIER          2'h0
`define MT_OOK              2'h1
`define MT_FSK              2'h2
`define MT_GFSK             2'h3

// carrier formula constants, result in 1/64000 of 10 MHz units
`define BAND_BASE           6'd24
`define FRAC_DIV            17'd64000
// hop step of 10 kHz equals 64 fraction units of 10 MHz/64000 = 156.25 Hz
`define HOP_UNIT            7'd64

// serial frame
`define SPI_ADDR_BITS       3'd7
`define SPI_FRAME_BITS      5'd16

`endif

// file: hw/carrier_calc.v
// derived offset and carrier frequency settings
`timescale 1ns/1ps
`include "modfreq_consts.vh"

module carrier_calc #(
  parameter FRAC_W = 16,
  parameter HOP_W  = 8
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst,
  // fields
  input  wire [4:0]           band_index,
  input  wire                 high_band_select,
  input  wire [9:0]           freq_offset_code,
  input  wire [FRAC_W-1:0]    carrier_fraction,
  input  wire [HOP_W-1:0]     hop_channel,
  input  wire [HOP_W-1:0]     hop_step,
  // results, carrier in units of 156.25 Hz, band, fraction and offset part times (hb+1), hop term not
  output reg  [31:0]          carrier_units_q,
  output reg  signed [13:0]   offset_units_q
);

  wire signed [18:0] frac_sum;
  wire [31:0]        band_term;
  wire [31:0]        hop_term;
  wire [31:0]        base_sum;
  wire [31:0]        carrier_d;

  // signed offset plus unsigned fraction
  assign frac_sum  = $signed({3'b000, carrier_fraction}) +
                     $signed({{9{freq_offset_code[9]}}, freq_offset_code});
  assign band_term = ({27'd0, band_index} + {26'd0, `BAND_BASE}) * {15'd0, `FRAC_DIV};
  // hop term is independent of band doubling, so it is added after the shift
  assign hop_term  = ({24'd0, hop_channel} * {24'd0, hop_step}) * {25'd0, `HOP_UNIT};
  assign base_sum  = band_term + {{13{frac_sum[18]}}, frac_sum};
  assign carrier_d = (high_band_select ? {base_sum[30:0], 1'b0} : base_sum) + hop_term;

  always @(posedge clk) begin
    if (rst) begin
      carrier_units_q <= 32'h0000_0000;
      offset_units_q  <= 14'sd0;
    end else begin
      carrier_units_q <= carrier_d;
      offset_units_q  <= high_band_select ?
                         {{3{freq_offset_code[9]}}, freq_offset_code, 1'b0} :
                         {{4{freq_offset_code[9]}}, freq_offset_code};
    end
  end

endmodule // carrier_calc

// file: hw/modulation_frequency_config.v
// modulation and frequency configuration register bank on the serial port
`timescale 1ns/1ps
`include "modfreq_consts.vh"

// Notes on behaviour
// - bit clock route: none, gpio, sdo, irq
// - source: gpio, sdi while deselected, fifo, pn9
// - invert bit flips tx and rx data
// - modulation type carrier, ook, fsk, gfsk
// - nine-bit deviation code, 625 Hz steps
// - offset is signed, scaled by band doubling
// - offset reads return latest afc result
// - high band select picks synthesizer range
// - band index steps 10 or 20 MHz
// - carrier formula with fraction, offset, hopping
// - documented reset values for all registers
// - hop step counts 10 kHz units
// - carrier fraction comes from two bytes
module modulation_frequency_config #(
  parameter FRAC_W = 16,
  parameter HOP_W  = 8
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst,
  // serial port pins
  input  wire                 chip_select_n,
  input  wire                 spi_clk,
  input  wire                 serial_in_pin,
  output reg                  serial_out_q,
  output reg                  serial_out_oe_q,
  // external fields from neighbouring registers and afc loop
  input  wire [FRAC_W-1:0]    carrier_fraction,
  input  wire [HOP_W-1:0]     hop_channel,
  input  wire [HOP_W-1:0]     hop_step,
  input  wire [9:0]           afc_result,
  // transmit data sources, bit clock and raw receive data
  input  wire                 gpio_tx_data,
  input  wire                 fifo_tx_data,
  input  wire                 pn9_tx_data,
  input  wire                 tx_bit_clock,
  input  wire                 rx_data_raw,
  // modem outputs
  output reg                  tx_data_q,
  output reg                  rx_data_q,
  output reg                  gpio_bit_clock_q,
  output reg                  irq_bit_clock_q,
  output reg  [1:0]           modulation_type_q,
  output reg                  async_mode_q,
  output reg  [8:0]           freq_deviation_code_q,
  output reg                  high_band_select_q,
  output reg                  sideband_select_q,
  output reg  [31:0]          carrier_units_q,
  output reg  signed [13:0]   offset_units_q
);

  // registers
  reg  [7:0]        mod_ctrl_q;
  reg  [7:0]        dev_low_q;
  reg  [7:0]        ofs_low_q;
  reg  [1:0]        ofs_high_q;
  reg  [6:0]        band_q;

  // pin synchronisers
  reg  [1:0]        cs_sync_q;
  reg  [1:0]        sck_sync_q;
  reg  [1:0]        sdi_sync_q;
  reg               sck_prev_q;

  // serial engine
  reg  [4:0]        bit_cnt_q;
  reg  [15:0]       shift_q;
  reg  [7:0]        rd_shift_q;
  reg               is_write_q;

  wire              cs_n_s;
  wire              sck_s;
  wire              sdi_s;
  wire              sck_rise;
  wire              sck_fall;
  wire [1:0]        route;
  wire [1:0]        source;
  wire [6:0]        addr_now;
  wire              src_bit;
  wire              direct_bit;
  wire [31:0]       carrier_w;
  wire signed [13:0] offset_w;
  reg  [7:0]        read_data;

  assign cs_n_s   = cs_sync_q[1];
  assign sck_s    = sck_sync_q[1];
  assign sdi_s    = sdi_sync_q[1];
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign route    = mod_ctrl_q[`F_ROUTE_HI:`F_ROUTE_LO];
  assign source   = mod_ctrl_q[`F_SRC_HI:`F_SRC_LO];
  // address is complete once the write flag and seven bits are in
  assign addr_now = shift_q[6:0];

  always @(posedge clk) begin
    if (rst) begin
      cs_sync_q  <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
    end else begin
      cs_sync_q  <= {cs_sync_q[0], chip_select_n};
      sck_sync_q <= {sck_sync_q[0], spi_clk};
      sdi_sync_q <= {sdi_sync_q[0], serial_in_pin};
      sck_prev_q <= sck_s;
    end
  end

  // read mux; offset registers return the afc result, not the stored value
  always @* begin
    case (addr_now)
      `ADDR_MOD_CTRL2: read_data = mod_ctrl_q;
      `ADDR_DEV_LOW:   read_data = dev_low_q;
      `ADDR_OFS_LOW:   read_data = afc_result[7:0];
      `ADDR_OFS_HIGH:  read_data = {6'h00, afc_result[9:8]};
      `ADDR_BAND_SEL:  read_data = {1'b0, band_q};
      default:         read_data = 8'h00;
    endcase
  end

  // serial frame: write flag, 7-bit address, 8 data bits, msb first
  always @(posedge clk) begin
    if (rst) begin
      bit_cnt_q       <= 5'd0;
      shift_q         <= 16'h0000;
      rd_shift_q      <= 8'h00;
      is_write_q      <= 1'b0;
      serial_out_oe_q <= 1'b0;
      mod_ctrl_q      <= `RST_MOD_CTRL2;
      dev_low_q       <= `RST_DEV_LOW;
      ofs_low_q       <= `RST_OFS_LOW;
      ofs_high_q      <= `RST_OFS_HIGH;
      band_q          <= `RST_BAND_SEL;
    end else if (cs_n_s) begin
      bit_cnt_q       <= 5'd0;
      serial_out_oe_q <= 1'b0;
    end else begin
      if (sck_rise && bit_cnt_q < `SPI_FRAME_BITS) begin
        shift_q   <= {shift_q[14:0], sdi_s};
        bit_cnt_q <= bit_cnt_q + 5'd1;
        if (bit_cnt_q == 5'd0)
          is_write_q <= sdi_s;
        if (bit_cnt_q == `SPI_FRAME_BITS - 5'd1 && is_write_q) begin
          // write flag sits in bit 14, so the address is the seven bits below it
          case (shift_q[13:7])
            `ADDR_MOD_CTRL2: mod_ctrl_q <= {shift_q[6:0], sdi_s};
            `ADDR_DEV_LOW:   dev_low_q  <= {shift_q[6:0], sdi_s};
            `ADDR_OFS_LOW:   ofs_low_q  <= {shift_q[6:0], sdi_s};
            `ADDR_OFS_HIGH:  ofs_high_q <= {shift_q[0], sdi_s};
            `ADDR_BAND_SEL:  band_q     <= {shift_q[5:0], sdi_s};
            default:         band_q     <= band_q;
          endcase
        end
      end
      if (sck_fall && bit_cnt_q == {2'b00, `SPI_ADDR_BITS} + 5'd1 && !is_write_q) begin
        rd_shift_q      <= read_data;
        serial_out_oe_q <= 1'b1;
      end else if (sck_fall && bit_cnt_q > {2'b00, `SPI_ADDR_BITS} + 5'd1) begin
        rd_shift_q <= {rd_shift_q[6:0], 1'b0};
      end
    end
  end

  // derived arithmetic
  carrier_calc #(
    .FRAC_W (FRAC_W),
    .HOP_W  (HOP_W)
  ) u_calc (
    .clk              (clk),
    .rst              (rst),
    .band_index       (band_q[`F_BAND_HI:0]),
    .high_band_select (band_q[`F_HIGHBAND]),
    .freq_offset_code ({ofs_high_q, ofs_low_q}),
    .carrier_fraction (carrier_fraction),
    .hop_channel      (hop_channel),
    .hop_step         (hop_step),
    .carrier_units_q  (carrier_w),
    .offset_units_q   (offset_w)
  );

  // sdi direct data is only meaningful while the port is deselected
  assign direct_bit = cs_n_s ? sdi_s : 1'b0;
  assign src_bit = (source == `SRC_GPIO) ? gpio_tx_data :
                   (source == `SRC_SDI)  ? direct_bit   :
                   (source == `SRC_FIFO) ? fifo_tx_data : pn9_tx_data;

  always @(posedge clk) begin
    if (rst) begin
      tx_data_q             <= 1'b0;
      rx_data_q             <= 1'b0;
      gpio_bit_clock_q      <= 1'b0;
      irq_bit_clock_q       <= 1'b0;
      serial_out_q          <= 1'b0;
      modulation_type_q     <= `MT_CARRIER;
      async_mode_q          <= 1'b1;
      freq_deviation_code_q <= 9'h000;
      high_band_select_q    <= 1'b0;
      sideband_select_q     <= 1'b0;
      carrier_units_q       <= 32'h0000_0000;
      offset_units_q        <= 14'sd0;
    end else begin
      tx_data_q         <= src_bit ^ mod_ctrl_q[`F_INV];
      rx_data_q         <= rx_data_raw ^ mod_ctrl_q[`F_INV];
      gpio_bit_clock_q  <= (route == `ROUTE_GPIO) & tx_bit_clock;
      irq_bit_clock_q   <= (route == `ROUTE_IRQ) & tx_bit_clock;
      // bit clock shares the data out pin only while no read is in progress
      serial_out_q      <= serial_out_oe_q ? rd_shift_q[7] :
                           ((route == `ROUTE_SDO) & tx_bit_clock);
      modulation_type_q <= mod_ctrl_q[`F_KIND_HI:`F_KIND_LO];
      async_mode_q      <= (route == `ROUTE_NONE);
      freq_deviation_code_q <= {mod_ctrl_q[`F_DEV_MSB], dev_low_q};
      high_band_select_q    <= band_q[`F_HIGHBAND];
      sideband_select_q     <= band_q[`F_SIDEBAND];
      carrier_units_q       <= carrier_w;
      offset_units_q        <= offset_w;
    end
  end

endmodule // modulation_frequency_config

// file: test/mfc_chk.sv
// port assertions for the configuration bank
`timescale 1ns/1ps
module mfc_chk #(parameter FRAC_W = 16, parameter HOP_W = 8) (
  input wire logic                clk, rst, chip_select_n, serial_out_oe_q, tx_bit_clock,
  input wire logic                rx_data_raw, rx_data_q, gpio_bit_clock_q, irq_bit_clock_q,
  input wire logic                async_mode_q, high_band_select_q, sideband_select_q,
  input wire logic [FRAC_W-1:0]   carrier_fraction,
  input wire logic [HOP_W-1:0]    hop_channel, hop_step,
  input wire logic [1:0]          modulation_type_q,
  input wire logic [8:0]          freq_deviation_code_q,
  input wire logic [31:0]         carrier_units_q,
  input wire logic signed [13:0]  offset_units_q
);
  // cycles since deselect; after 8 no frame can still commit
  logic [3:0] idle_q;
  wire        settled = idle_q[3];
  always_ff @(posedge clk) idle_q <= (rst | ~chip_select_n) ? 4'h0 : idle_q + {3'h0, ~&idle_q};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_reset_clear: assert property (disable iff (1'b0)
    rst ##1 rst |-> async_mode_q && freq_deviation_code_q == 9'h000) else $error("no clear");
  chk_reset_values: assert property ($fell(rst) |-> ##[0:3]
    (freq_deviation_code_q == 9'h020 && high_band_select_q && sideband_select_q))
    else $error("bad reset values");
  chk_clock_gated: assert property ((gpio_bit_clock_q | irq_bit_clock_q) |->
    $past(tx_bit_clock) && !(gpio_bit_clock_q && irq_bit_clock_q)) else $error("bad clock");
  chk_async_quiet: assert property (settled && async_mode_q |->
    !gpio_bit_clock_q && !irq_bit_clock_q) else $error("clock in async mode");
  chk_read_ends: assert property (settled |-> !serial_out_oe_q)
    else $error("read drive after deselect");
  chk_fields_hold: assert property (settled |-> $stable(freq_deviation_code_q) &&
    $stable(modulation_type_q) && $stable({high_band_select_q, sideband_select_q})
    && $stable(offset_units_q)) else $error("field moved");
  chk_rx_invert: assert property (settled |-> (rx_data_q ^ $past(rx_data_raw)) ==
    ($past(rx_data_q) ^ $past(rx_data_raw, 2))) else $error("rx polarity");
  chk_offset_even: assert property (settled && high_band_select_q |->
    !offset_units_q[0]) else $error("offset not doubled");
  chk_offset_range: assert property (settled && !high_band_select_q |->
    offset_units_q[13:9] inside {5'h00, 5'h1f}) else $error("offset sign");
  chk_carrier_hold: assert property ((settled && $stable(carrier_fraction) &&
    $stable({hop_channel, hop_step}))[*3] |-> $stable(carrier_units_q)) else $error("carrier");
  cover property (serial_out_oe_q);
  cover property (gpio_bit_clock_q);
  cover property (irq_bit_clock_q);
  cover property (settled && !high_band_select_q);
endmodule // mfc_chk
bind modulation_frequency_config mfc_chk #(.FRAC_W(FRAC_W), .HOP_W(HOP_W)) chk_u (.clk, .rst,
  .chip_select_n, .serial_out_oe_q, .tx_bit_clock, .rx_data_raw, .rx_data_q, .gpio_bit_clock_q,
  .irq_bit_clock_q, .async_mode_q, .high_band_select_q, .sideband_select_q, .carrier_fraction,
  .hop_channel, .hop_step, .modulation_type_q, .freq_deviation_code_q, .carrier_units_q,
  .offset_units_q);

// file: test/modulation_frequency_config_tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module modulation_frequency_config_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic gpio_tx_data = 1'b0, fifo_tx_data = 1'b0, pn9_tx_data = 1'b0, direct_in = 1'b0;
  logic tx_bit_clock = 1'b0, rx_data_raw = 1'b0;
  logic [15:0] carrier_fraction = 16'h0000;
  logic [7:0] hop_channel = 8'h00, hop_step = 8'h00, rd, v71, v72, v75;
  logic [9:0] afc_result = 10'h000, ofs;
  logic [3:0] s;
  logic [6:0] ra[5] = '{7'h71, 7'h72, 7'h75, 7'h70, 7'h76};
  logic [7:0] re[5] = '{8'h00, 8'h20, 8'h75, 8'h00, 8'h00};
  wire chip_select_n, spi_clk, serial_in_pin, serial_out_q, serial_out_oe_q, tx_data_q;
  wire rx_data_q, gpio_bit_clock_q, irq_bit_clock_q, async_mode_q;
  wire high_band_select_q, sideband_select_q;
  wire [1:0] modulation_type_q;
  wire [8:0] freq_deviation_code_q;
  wire [31:0] carrier_units_q;
  wire signed [13:0] offset_units_q;
  int fails = 0, n_checks = 0;
  always #25 clk = ~clk;
  modulation_frequency_config dut_u (.clk, .rst, .chip_select_n, .spi_clk, .serial_in_pin,
    .serial_out_q, .serial_out_oe_q, .carrier_fraction, .hop_channel, .hop_step, .afc_result,
    .gpio_tx_data, .fifo_tx_data, .pn9_tx_data, .tx_bit_clock, .rx_data_raw, .tx_data_q,
    .rx_data_q, .gpio_bit_clock_q, .irq_bit_clock_q, .modulation_type_q, .async_mode_q,
    .freq_deviation_code_q, .high_band_select_q, .sideband_select_q, .carrier_units_q,
    .offset_units_q);
  spi_host_model host_u (.clk, .serial_out_q, .direct_in, .chip_select_n, .spi_clk,
    .serial_in_pin);
  task automatic check(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // carrier in 156.25 Hz units; hop term stays outside the band doubling
  function automatic logic [31:0] carrier(input logic [7:0] b, input logic [9:0] f);
    return (({27'h0, b[4:0]} + 32'h0000_0018) * 32'h0000_fa00 + {16'h0, carrier_fraction}
      + {{22{f[9]}}, f}) * ({31'h0, b[5]} + 32'h0000_0001)
      + {24'h0, hop_channel} * {24'h0, hop_step} * 32'h0000_0040;
  endfunction
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(50 * 40000);
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hbed1_e3f5));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'({async_mode_q, high_band_select_q, sideband_select_q, modulation_type_q,
      freq_deviation_code_q}), 32'h0000_3820);
    check(carrier_units_q, carrier(8'h75, 10'h000));
    foreach (ra[i]) begin
      host_u.xfer(1'b0, ra[i], 8'h00, rd);
      check(32'(rd), 32'(re[i]));
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      // gfsk only meets a buffered source here, so no route is owed
      v71 = {i[1:0], 2'(i + 1), i[0], i[1], 2'(i + 2)};
      host_u.xfer(1'b1, 7'h71, v71, rd);
      host_u.xfer(1'b0, 7'h71, 8'h00, rd);
      check(32'(rd), 32'(v71));
      for (int j = 0; j < 2; j++) begin
        {gpio_tx_data, fifo_tx_data, pn9_tx_data, direct_in, rx_data_raw} <= 5'($urandom);
        tx_bit_clock <= j[0];
        repeat (6) @(posedge clk);
        s = {pn9_tx_data, fifo_tx_data, direct_in, gpio_tx_data};
        check(32'(tx_data_q), 32'(v71[3] ^ s[v71[5:4]]));
        check(32'(rx_data_q), 32'(v71[3] ^ rx_data_raw));
        check(32'({gpio_bit_clock_q, irq_bit_clock_q, async_mode_q}), 32'({v71[7:6] == 2'h1
          && j[0], v71[7:6] == 2'h3 && j[0], v71[7:6] == 2'h0}));
        if (v71[7:6] == 2'h2) check(32'(serial_out_q), 32'(j[0]));
        check(32'({modulation_type_q, freq_deviation_code_q[8]}), 32'({v71[1:0], v71[2]}));
      end
    end
    $display("test modes done");
    for (int k = 0; k < 6; k++) begin
      {v72, v75, ofs} = 26'($urandom);
      if (k == 0) ofs = 10'h200;
      if (k == 1) {v75, ofs} = {8'hbf, 10'h1ff};
      if (k == 2) v75 = 8'h00;
      // deviation msb stays set from the modes test: index in range at default rate
      {carrier_fraction, hop_channel, hop_step} <= 32'($urandom);
      afc_result <= 10'($urandom);
      host_u.xfer(1'b1, 7'h72, v72, rd);
      host_u.xfer(1'b1, 7'h73, ofs[7:0], rd);
      host_u.xfer(1'b1, 7'h74, {6'h3f, ofs[9:8]}, rd);
      host_u.xfer(1'b1, 7'h75, v75, rd);
      check(32'(freq_deviation_code_q), 32'({v71[2], v72}));
      check(32'({high_band_select_q, sideband_select_q}), 32'({v75[5], v75[6]}));
      check(32'($unsigned(offset_units_q)), 32'(14'({{4{ofs[9]}}, ofs} << v75[5])));
      check(carrier_units_q, carrier(v75, ofs));
      host_u.xfer(1'b0, 7'h75, 8'h00, rd);
      check(32'(rd), 32'(v75 & 8'h7f));
      host_u.xfer(1'b0, 7'h73, 8'h00, rd);
      check(32'(rd), 32'(afc_result[7:0]));
      host_u.xfer(1'b0, 7'h74, 8'h00, rd);
      check(32'(rd), 32'({6'h0, afc_result[9:8]}));
    end
    $display("test fields done");
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(freq_deviation_code_q), 32'h0000_0020);
    $display("test second reset done");
    end_of_test();
  end
endmodule // modulation_frequency_config_tb

// file: test/spi_host_model.sv
// host serial port master model
`timescale 1ns/1ps
module spi_host_model #(parameter int HALF = 8) (
  input wire logic  clk, serial_out_q, direct_in,
  output logic      chip_select_n = 1'b1,
  output logic      spi_clk = 1'b0,
  output wire logic serial_in_pin
);
  logic frame_bit = 1'b0;
  // direct tx data only while deselected
  assign serial_in_pin = chip_select_n ? direct_in : frame_bit;
  // slow clock: design samples the pins, needs many clk per half period
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] frame;
    q = 8'h00;
    frame = {wr, a, d};
    @(posedge clk);
    chip_select_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      frame_bit <= frame[i];
      spi_clk <= 1'b0;
      repeat (HALF) @(posedge clk);
      spi_clk <= 1'b1;
      repeat (HALF) @(posedge clk);
      if (i < 8) q[i] = serial_out_q;
    end
    spi_clk <= 1'b0;
    repeat (HALF) @(posedge clk);
    chip_select_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
endmodule // spi_host_model
